/* File: core/meas_sync_ctrl.sv */
// Purpose: Measurement pipeline timing, laser gating and sync link control
// Assumes: Inputs synchronous to aclk; sync_in_pos/neg already at logic level
// Notes: Saved configuration is held in the saved field, reloaded at reset
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module meas_sync_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire meas_sync_pkg::axil_req_t axil_req,
  output meas_sync_pkg::axil_rsp_t axil_rsp,
  input wire logic laser_enable_n,
  input wire logic mfi_in,
  input wire logic sync_in_pos,
  input wire logic sync_in_neg,
  input wire logic [31:0] sample_in,
  output meas_sync_pkg::sync_out_t sync_out,
  output logic term_en,
  output logic laser_on,
  output meas_sync_pkg::power_t laser_power,
  output logic acquire,
  output logic result_valid,
  output logic [31:0] result_data
);
  import meas_sync_pkg::*;

  typedef struct packed {
    cfg_t cfg;
    cfg_t saved;
    logic saved_ok;
    logic [31:0] period;
    logic [31:0] count;
    logic phase;
    logic [31:0] pipe0;
    logic [31:0] pipe1;
    logic [31:0] pipe2;
    logic [31:0] pipe3;
    logic [PIPE_DEPTH-1:0] vld;
    logic [31:0] result;
    logic res_vld;
    logic acq;
    logic sync_prev;
    logic mfi_prev;
    logic conflict;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  // Power-up contents of the permanent copy
  cfg_t saved_keep_ff = CFG_RESET;
  logic saved_keep_ok_ff = 1'b0;

  function automatic logic is_master(input role_t r);
    return (r == ROLE_MASTER) || (r == ROLE_MASTER_ALT);
  endfunction

  function automatic logic is_slave(input role_t r);
    return (r == ROLE_SLAVE) || (r == ROLE_SLAVE_ALT) ||
      (r == ROLE_SLAVE_VIA_MULTIFUNCTION_INPUT);
  endfunction

  logic tick;
  logic sync_level;
  logic sync_edge;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic alt_role;

  assign alt_role = (st_ff.cfg.role == ROLE_MASTER_ALT) || (st_ff.cfg.role == ROLE_SLAVE_ALT);
  assign sync_level = (st_ff.cfg.role == ROLE_SLAVE_VIA_MULTIFUNCTION_INPUT) ? mfi_in :
    sync_in_pos;

  always_comb begin
    nxt_st = st_ff;
    tick = 1'b0;
    sync_edge = 1'b0;
    nxt_st.acq = 1'b0;
    nxt_st.res_vld = 1'b0;
    nxt_st.sync_prev = sync_in_pos;
    nxt_st.mfi_prev = mfi_in;
    // Slave cycles start on the rising sync edge
    if (st_ff.cfg.role == ROLE_SLAVE_VIA_MULTIFUNCTION_INPUT) begin
      sync_edge = mfi_in && !st_ff.mfi_prev;
    end else begin
      sync_edge = sync_in_pos && !st_ff.sync_prev;
    end
    // Two masters: a master sees the line disagree with its own drive
    if (is_master(st_ff.cfg.role) && st_ff.count > 32'h0000_0001 &&
        (sync_in_pos != st_ff.phase || sync_in_neg == st_ff.phase)) begin
      nxt_st.conflict = 1'b1;
    end
    if (!is_master(st_ff.cfg.role)) begin
      nxt_st.conflict = 1'b0;
    end
    // Cycle timer: one cycle per measuring-rate period
    if (is_slave(st_ff.cfg.role)) begin
      tick = sync_edge;
      nxt_st.count = 32'h0000_0000;
    end else if (st_ff.count >= st_ff.period - 32'h0000_0001) begin
      tick = 1'b1;
      nxt_st.count = 32'h0000_0000;
    end else begin
      nxt_st.count = st_ff.count + 32'h0000_0001;
    end
    if (st_ff.conflict || nxt_st.conflict) begin
      tick = 1'b0;
    end
    if (tick) begin
      nxt_st.acq = 1'b1;
      nxt_st.phase = is_slave(st_ff.cfg.role) ? 1'b1 : ~st_ff.phase;
      // Four overlapped stages, one result per cycle
      nxt_st.pipe0 = sample_in;
      nxt_st.pipe1 = st_ff.pipe0;
      nxt_st.pipe2 = st_ff.pipe1;
      nxt_st.pipe3 = st_ff.pipe2;
      nxt_st.vld = {st_ff.vld[PIPE_DEPTH-2:0], 1'b1};
      nxt_st.result = st_ff.pipe3;
      nxt_st.res_vld = st_ff.vld[PIPE_DEPTH-1];
    end
    // Register bus
    aw_fire = axil_req.awvalid && !st_ff.aw_got && !st_ff.bvalid;
    w_fire = axil_req.wvalid && !st_ff.w_got && !st_ff.bvalid;
    ar_fire = axil_req.arvalid && !st_ff.rvalid;
    if (aw_fire) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = axil_req.awaddr;
    end
    if (w_fire) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = axil_req.wdata;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      unique case (st_ff.awaddr)
        ADDR_CTRL: begin
          nxt_st.cfg.power = power_t'(st_ff.wdata[CTRL_POWER_LSB +: 2]);
          if (st_ff.wdata[CTRL_ROLE_LSB +: 3] <= 3'(ROLE_INACTIVE)) begin
            nxt_st.cfg.role = role_t'(st_ff.wdata[CTRL_ROLE_LSB +: 3]);
          end else begin
            nxt_st.bresp = RESP_SLVERR;
          end
          nxt_st.cfg.term = st_ff.wdata[CTRL_TERM_BIT];
        end
        ADDR_PERIOD: begin
          if (st_ff.wdata >= 32'(MIN_PERIOD_CYC)) begin
            nxt_st.period = st_ff.wdata;
          end else begin
            nxt_st.bresp = RESP_SLVERR;
          end
        end
        ADDR_SAVE: begin
          if (st_ff.wdata == SAVE_KEY) begin
            nxt_st.saved = st_ff.cfg;
            nxt_st.saved_ok = 1'b1;
          end
        end
        ADDR_SAMPLE, ADDR_RESULT, ADDR_STATUS: begin
          nxt_st.bresp = RESP_SLVERR;
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.bvalid && axil_req.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (ar_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      unique case (axil_req.araddr)
        ADDR_CTRL: begin
          nxt_st.rdata = {23'h00_0000, st_ff.cfg.term, 1'b0, st_ff.cfg.role, 2'b00,
            st_ff.cfg.power};
        end
        ADDR_PERIOD: nxt_st.rdata = st_ff.period;
        ADDR_SAMPLE: nxt_st.rdata = st_ff.pipe0;
        ADDR_RESULT: nxt_st.rdata = st_ff.result;
        ADDR_STATUS: begin
          nxt_st.rdata = {24'h00_0000, st_ff.saved_ok, st_ff.conflict, laser_on,
            st_ff.phase, st_ff.vld};
        end
        ADDR_SAVE: nxt_st.rdata = {31'h0000_0000, st_ff.saved_ok};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && axil_req.rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      // Unsaved settings drop; the saved copy is restored
      st_ff.cfg <= saved_keep_ok_ff ? saved_keep_ff : CFG_RESET;
      st_ff.saved <= saved_keep_ff;
      st_ff.saved_ok <= saved_keep_ok_ff;
      st_ff.period <= RESET_PERIOD_CYC;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Non-volatile copy: survives reset
  always_ff @(posedge aclk) begin
    if (aresetn) begin
      saved_keep_ff <= st_ff.saved;
      saved_keep_ok_ff <= st_ff.saved_ok;
    end
  end

  // Laser gating: power, ground input, alternation and conflict
  assign laser_on = !laser_enable_n && (st_ff.cfg.power != POWER_OFF) && !st_ff.conflict &&
    (!alt_role || (st_ff.cfg.role == ROLE_MASTER_ALT ? st_ff.phase : !sync_level));
  assign laser_power = laser_on ? st_ff.cfg.power : POWER_OFF;

  // Master drives symmetric differential pulses
  assign sync_out.drive_en = is_master(st_ff.cfg.role);
  assign sync_out.pos_out = is_master(st_ff.cfg.role) && st_ff.phase;
  assign sync_out.neg_out = is_master(st_ff.cfg.role) && !st_ff.phase;
  assign term_en = is_slave(st_ff.cfg.role) && st_ff.cfg.term;
  assign acquire = st_ff.acq;
  assign result_valid = st_ff.res_vld;
  assign result_data = st_ff.result;

  assign axil_rsp.awready = !st_ff.aw_got && !st_ff.bvalid;
  assign axil_rsp.wready = !st_ff.w_got && !st_ff.bvalid;
  assign axil_rsp.bvalid = st_ff.bvalid;
  assign axil_rsp.bresp = st_ff.bresp;
  assign axil_rsp.arready = !st_ff.rvalid;
  assign axil_rsp.rvalid = st_ff.rvalid;
  assign axil_rsp.rdata = st_ff.rdata;
  assign axil_rsp.rresp = st_ff.rresp;

  // Helper: acquisitions since reset, saturating at 7
  logic [2:0] since_acq_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_acq_ff <= 3'h0;
    end else if (st_ff.acq && since_acq_ff != 3'h7) begin
      since_acq_ff <= since_acq_ff + 3'h1;
    end
  end

  pipe_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    result_valid |-> st_ff.vld == 4'hf)
    else $error("Result before four cycles");
  pipe_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    result_valid |-> since_acq_ff >= 3'h4)
    else $error("Result with fewer than four acquisitions");
  pipe_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acquire && $past(st_ff.vld[3])) |-> result_valid)
    else $error("Missing result in a full pipeline");
  pipe_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    result_valid |-> result_data == $past(st_ff.pipe3))
    else $error("Result data not from stage four");
  laser_gnd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    laser_enable_n |-> !laser_on)
    else $error("Laser on without ground input");
  laser_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.cfg.power == POWER_OFF) |-> !laser_on)
    else $error("Laser on at power off");
  conflict_laser_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.conflict |-> (!laser_on && !acquire))
    else $error("Laser or measurement during master conflict");
  sync_diff_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_out.drive_en |-> (sync_out.pos_out != sync_out.neg_out))
    else $error("Sync pair not differential");
  master_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acquire && !is_slave(st_ff.cfg.role) && !st_ff.conflict && $stable(st_ff.period))
    |-> (st_ff.count == 32'h0000_0000 || st_ff.conflict))
    else $error("Cycle timer out of step");
  slave_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_slave(st_ff.cfg.role) && $stable(st_ff.cfg.role) && acquire) |->
    $past(sync_edge))
    else $error("Slave cycle without sync edge");
  alt_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.cfg.role == ROLE_MASTER_ALT && laser_on) |-> sync_out.pos_out)
    else $error("Alternating master laser out of phase");
endmodule // meas_sync_ctrl

/* File: core/meas_sync_pkg.sv */
// Purpose: Constants and types for the measurement pipeline and sync control
// Assumes: 50 MHz aclk, AXI4-Lite register access
// Notes: Offsets, reset values and cycle counts are localparams here
// Function
// - Each measurement passes four processing cycles before its result appears.
// - One cycle lasts one measuring-rate period; 100 us at 10 kHz.
// - Value N acquired in one cycle is output exactly four cycles later.
// - Stages overlap, so one new result is emitted every cycle.
// - Unsaved settings are lost at reset; saved settings are restored.
// - Laser power selects full, medium, reduced or off; off disables laser.
// - Laser may be active only while the laser-enable input is grounded.
// - Sync role is slave, alt slave, multifunction slave, master, alt master, inactive.
// - A master's sync output paces all attached slaves.
// - Simultaneous sync: one master, one slave, both measure in same cycle; a slave measures only on rising sync edges, so every second master cycle.
// - Alternating sync: master and slave lasers run in opposite phases.
// - A master drives symmetric differential sync pulses to all slaves.
// - On detecting two masters on the link the laser is shut off.
package meas_sync_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MAX_RATE_HZ = 10_000;
  localparam int unsigned MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_HZ;
  localparam logic [31:0] RESET_PERIOD_CYC = 32'h0000_30d4;
  localparam int unsigned PIPE_DEPTH = 4;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SAVE = 8'h14;
  localparam int unsigned CTRL_POWER_LSB = 0;
  localparam int unsigned CTRL_ROLE_LSB = 4;
  localparam int unsigned CTRL_TERM_BIT = 8;
  localparam logic [31:0] SAVE_KEY = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {POWER_FULL, POWER_MEDIUM, POWER_REDUCED, POWER_OFF} power_t;
  typedef enum logic [2:0] {
    ROLE_SLAVE, ROLE_SLAVE_ALT, ROLE_SLAVE_VIA_MULTIFUNCTION_INPUT, ROLE_MASTER,
    ROLE_MASTER_ALT, ROLE_INACTIVE
  } role_t;

  typedef struct packed {
    power_t power;
    role_t role;
    logic term;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{power: POWER_FULL, role: ROLE_INACTIVE, term: 1'b0};

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  typedef struct packed {
    logic pos_out;
    logic neg_out;
    logic drive_en;
  } sync_out_t;
endpackage

/* File: tb/sync_peer.sv */
// Purpose: Far-side sensor driving the sync pair as a master
// Assumes: Half period given in aclk cycles
// Notes: Released lines toggle every cycle
`timescale 1ns/1ps
module sync_peer (
  input wire logic aclk,
  input wire logic en,
  input wire logic [15:0] half,
  output logic pos,
  output logic neg
);
  logic [15:0] cnt_ff = 16'h0000;
  logic ph_ff = 1'b0;
  always @(posedge aclk) begin
    cnt_ff <= (!en || cnt_ff == half - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
    if (!en || cnt_ff == half - 16'h0001) ph_ff <= ~ph_ff;
  end
  assign pos = ph_ff;
  assign neg = ~ph_ff;
endmodule // sync_peer

/* File: tb/measurement_pipeline_sync_control_test.sv */
// Purpose: Register, pipeline, laser and sync checks
// Assumes: AXI4-Lite master tasks, one peer sensor
// Notes: Period shortened to 5000 cycles
`timescale 1ns/1ps
module measurement_pipeline_sync_control_test;
  import meas_sync_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axil_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  axil_rsp_t rsp;
  logic laser_enable_n = 1'b0;
  logic peer_en = 1'b0;
  logic peer_pos, peer_neg, sync_in_pos, sync_in_neg;
  logic [31:0] sample_in = 32'h0000_0000;
  sync_out_t sync_out;
  logic term_en, laser_on, acquire, result_valid;
  power_t laser_power;
  logic [31:0] result_data, q;
  logic [1:0] r;
  logic [31:0] hist [0:63];
  int n_errors = 0, checks_done = 0, n = 0, gap = 0, per = 0, mode = 0;

  assign sync_in_pos = (sync_out.drive_en && !peer_en) ? sync_out.pos_out : peer_pos;
  assign sync_in_neg = (sync_out.drive_en && !peer_en) ? sync_out.neg_out : peer_neg;

  meas_sync_ctrl meas_sync_ctrl_i (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .laser_enable_n(laser_enable_n), .mfi_in(1'b0),
    .sync_in_pos(sync_in_pos), .sync_in_neg(sync_in_neg), .sample_in(sample_in),
    .sync_out(sync_out), .term_en(term_en), .laser_on(laser_on),
    .laser_power(laser_power), .acquire(acquire), .result_valid(result_valid),
    .result_data(result_data));
  sync_peer sync_peer_i (.aclk(aclk), .en(peer_en), .half(16'h03e8), .pos(peer_pos),
    .neg(peer_neg));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, done;
    if (w) begin
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
    end else begin
      req.araddr <= a;
      req.arvalid <= 1'b1;
    end
    do begin
      #1;
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      tr = req.arvalid & rsp.arready;
      done = w ? rsp.bvalid : rsp.rvalid;
      q = rsp.rdata;
      r = w ? rsp.bresp : rsp.rresp;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tr) req.arvalid <= 1'b0;
    end while (!done);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    xfer(1'b1, a, d);
    chk(r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
    chk(r, er);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Stream monitor: spacing, latency and phase relations
  always @(posedge aclk) begin
    if (aresetn && mode != 0) begin
      gap <= gap + 1;
      if (gap == 2500) sample_in <= sample_in + 32'h0001_0003;
      if (mode == 1) chk(result_valid, acquire && n >= 4);
      if (acquire) begin
        hist[n % 64] = sample_in;
        if (per > 0 && n > 0) chk(gap, per);
        if (mode == 1 && n >= 4) chk(result_data, hist[(n - 4) % 64]);
        gap <= 1;
        n <= n + 1;
      end
      if (mode == 3) chk(laser_on, sync_out.pos_out);
      if (mode == 4) chk(laser_on, !sync_in_pos);
    end
  end

  initial begin
    repeat (95000) @(posedge aclk);
    n_errors++;
    complete_run;
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, 32'h0000_0050, RESP_OKAY);
    rd(ADDR_PERIOD, RESET_PERIOD_CYC, RESP_OKAY);
    rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    wr(ADDR_PERIOD, 32'h0000_1387, RESP_SLVERR);
    wr(ADDR_PERIOD, 32'h0000_1388, RESP_OKAY);
    per <= 32'h0000_1388;
    mode <= 1;
    wait (n >= 6);
    @(posedge aclk);
    mode <= 0;
    per <= 0;
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, 32'h0000_0053 - p, RESP_OKAY);
      #1;
      chk(laser_on, p != 0);
      chk(laser_power, 3 - p);
      @(posedge aclk);
    end
    laser_enable_n <= 1'b1;
    @(posedge aclk);
    #1;
    chk(laser_on, 1'b0);
    @(posedge aclk);
    laser_enable_n <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_CTRL, k << 4, RESP_OKAY);
      rd(ADDR_CTRL, k << 4, RESP_OKAY);
    end
    wr(ADDR_CTRL, 32'h0000_0060, RESP_SLVERR);
    rd(ADDR_CTRL, 32'h0000_0050, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0030, RESP_OKAY);
    per <= 32'h0000_1388;
    mode <= 2;
    n <= 0;
    wait (n >= 2);
    #1;
    chk(sync_out.drive_en, 1'b1);
    chk(sync_out.pos_out, !sync_out.neg_out);
    @(posedge aclk);
    wr(ADDR_CTRL, 32'h0000_0040, RESP_OKAY);
    mode <= 3;
    n <= 0;
    wait (n >= 3);
    @(posedge aclk);
    per <= 0;
    mode <= 2;
    peer_en <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0030, RESP_OKAY);
    repeat (50) @(posedge aclk);
    n <= 0;
    repeat (6000) @(posedge aclk);
    #1;
    chk(laser_on, 1'b0);
    chk(n, 0);
    @(posedge aclk);
    wr(ADDR_CTRL, 32'h0000_0100, RESP_OKAY);
    #1;
    chk(term_en, 1'b1);
    per <= 32'h0000_07d0;
    n <= 0;
    wait (n >= 5);
    @(posedge aclk);
    per <= 0;
    wr(ADDR_CTRL, 32'h0000_0010, RESP_OKAY);
    mode <= 4;
    n <= 0;
    wait (n >= 3);
    @(posedge aclk);
    mode <= 0;
    peer_en <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0051, RESP_OKAY);
    wr(ADDR_SAVE, SAVE_KEY, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0053, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, 32'h0000_0051, RESP_OKAY);
    rd(ADDR_SAVE, 32'h0000_0001, RESP_OKAY);
    complete_run;
  end
endmodule // measurement_pipeline_sync_control_test
